/* clk_div2.sv */
// Divide-by-two toggle for the CPU clock output function.
// Assumes mclk is the CPU clock; held low while not enabled.
`timescale 1ns/1ps
`default_nettype none
module clk_div2 (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  output logic div_out
);

  logic div_nxt;

  assign div_nxt = enable ? ~div_out : 1'b0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_out <= 1'b0;
    end else begin
      div_out <= div_nxt;
    end
  end

endmodule : clk_div2
`default_nettype wire

/* pad_load.sv */
// Board side of the two port C pads: device drive, pull-up, board source.
// Assumes ext is what a crystal, clock source or load puts on a free pad.
`timescale 1ns/1ps
`default_nettype none
module pad_load (
  input wire logic [1:0] out,
  input wire logic [1:0] oe,
  input wire logic [1:0] pull_en,
  input wire logic [1:0] ext,
  output logic [1:0] pad
);
  // Device drive wins, then pull-up, else the board level
  assign pad = (oe & out) | (~oe & (pull_en | ext));
endmodule : pad_load
`default_nettype wire

/* pin_sync.sv */
// Two-flop synchroniser for the port C pad inputs.
// Assumes inputs arrive asynchronously to mclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* port_c_clock_mux.sv */
// Function multiplexer for the two-pin port C: general I/O, oscillator
// pins and divided clock output.
// Assumes clock source and oscillator options come static from the flash
// configuration logic on mclk; pad inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module port_c_clock_mux (
  input wire logic mclk,
  input wire logic resetn,
  input wire port_c_mux_pkg::clk_src_t cpu_clk_src,
  input wire logic xtal_osc_sel,
  input wire logic timer_from_xtal,
  input wire logic clock_output_enable,
  input wire logic [1:0] pin0_mode,
  input wire logic [1:0] pin1_mode,
  input wire logic pin0_data,
  input wire logic pin1_data,
  input wire logic port_c_bit0_in,
  input wire logic port_c_bit1_in,
  output logic port_c_bit0_out,
  output logic port_c_bit0_oe,
  output logic port_c_bit0_pullup,
  output logic port_c_bit1_out,
  output logic port_c_bit1_oe,
  output logic port_c_bit1_pullup,
  output logic osc_amp_output,
  output logic osc_amp_input,
  output logic osc_input_level,
  output logic divided_clock_output,
  output logic [1:0] pin_value,
  output logic [port_c_mux_pkg::STATUS_WIDTH-1:0] mux_status
);
  import port_c_mux_pkg::*;

  // Pad drive decode for one pin
  function automatic logic [2:0] pad_drive(
    input logic [1:0] mode,
    input logic data
  );
    logic [2:0] d;
    d = 3'h0;
    case (mode)
      MODE_QUASI: begin
        d = {1'b0, ~data, 1'b1};
      end
      MODE_PUSH_PULL: begin
        d = {data, 1'b1, 1'b0};
      end
      MODE_OPEN_DRAIN: begin
        d = {1'b0, ~data, 1'b0};
      end
      default: begin
        d = 3'h0;
      end
    endcase
    return d;
  endfunction : pad_drive

  // Configuration captured on mclk
  logic [1:0] mode_r [PIN_COUNT];
  logic [1:0] mode_nxt [PIN_COUNT];
  logic divided_clock_output_en_r;
  logic divided_clock_output_en_nxt;
  pin_fn_t fn0_r;
  pin_fn_t fn0_nxt;
  pin_fn_t fn1_r;
  pin_fn_t fn1_nxt;

  // Source qualification
  wire src_is_xtal = (cpu_clk_src == CLK_SRC_XTAL);
  wire src_is_ext = (cpu_clk_src == CLK_SRC_EXT);
  wire src_is_internal = (cpu_clk_src == CLK_SRC_RC) ||
                         (cpu_clk_src == CLK_SRC_WDT);
  wire crystal_active = xtal_osc_sel || src_is_xtal || timer_from_xtal;
  wire divided_clock_output_allowed = (src_is_internal || src_is_ext) &&
                        !timer_from_xtal && !crystal_active; // R4
  wire pin1_osc_needed = src_is_ext || crystal_active; // R6
  wire pin1_gpio_ok = src_is_internal && !timer_from_xtal &&
                      !crystal_active; // R7

  assign divided_clock_output_en_nxt = clock_output_enable;

  // Pin 0 function select
  always_comb begin
    if (crystal_active) begin
      fn0_nxt = FN_OSC; // R5
    end else if (divided_clock_output_en_r && divided_clock_output_allowed) begin
      fn0_nxt = FN_DIVIDED_CLOCK_OUTPUT; // R3
    end else begin
      fn0_nxt = FN_GPIO;
    end
  end

  // Pin 1 function select
  always_comb begin
    if (pin1_osc_needed) begin
      fn1_nxt = FN_OSC; // R6
    end else if (pin1_gpio_ok) begin
      fn1_nxt = FN_GPIO; // R7
    end else begin
      fn1_nxt = FN_OSC;
    end
  end

  assign mode_nxt[PIN0] = pin0_mode;
  assign mode_nxt[PIN1] = pin1_mode;

  // Reset puts both pins input only, pull-ups off
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_mode
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          mode_r[gi] <= MODE_RESET; // R1
        end else begin
          mode_r[gi] <= mode_nxt[gi]; // R2
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divided_clock_output_en_r <= 1'b0; // R12
      fn0_r <= FN_GPIO;
      fn1_r <= FN_GPIO;
    end else begin
      divided_clock_output_en_r <= divided_clock_output_en_nxt;
      fn0_r <= fn0_nxt;
      fn1_r <= fn1_nxt;
    end
  end

  // Divided CPU clock
  logic div_clk;
  wire div_run = (fn0_r == FN_DIVIDED_CLOCK_OUTPUT);

  clk_div2 u_div (
    .mclk(mclk),
    .resetn(resetn),
    .enable(div_run),
    .div_out(div_clk)
  );

  // Pad input synchroniser
  logic [1:0] pad_sync;

  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in({port_c_bit1_in, port_c_bit0_in}),
    .sync_out(pad_sync)
  );

  // Per-pin general drive {out, oe, pullup}
  wire [2:0] gp0 = pad_drive(mode_r[PIN0], pin0_data); // R2
  wire [2:0] gp1 = pad_drive(mode_r[PIN1], pin1_data); // R2

  // Pin 0 pad selection
  logic [2:0] pad0_nxt;
  always_comb begin
    case (fn0_r)
      FN_GPIO: begin
        pad0_nxt = gp0;
      end
      FN_DIVIDED_CLOCK_OUTPUT: begin
        pad0_nxt = {div_clk, 1'b1, 1'b0}; // R3
      end
      FN_OSC: begin
        pad0_nxt = 3'h0; // R5
      end
      default: begin
        pad0_nxt = 3'h0;
      end
    endcase
  end

  // Pin 1 pad selection
  logic [2:0] pad1_nxt;
  always_comb begin
    case (fn1_r)
      FN_GPIO: begin
        pad1_nxt = gp1;
      end
      FN_OSC: begin
        pad1_nxt = 3'h0; // R6
      end
      default: begin
        pad1_nxt = 3'h0;
      end
    endcase
  end

  wire amp_out_nxt = (fn0_r == FN_OSC); // R5
  wire amp_in_nxt = (fn1_r == FN_OSC); // R6
  wire osc_lvl_nxt = amp_in_nxt & pad_sync[PIN1];
  wire divout_nxt = div_run & div_clk;

  // Status image with reserved and fixed bits
  logic [STATUS_WIDTH-1:0] status_nxt;
  always_comb begin
    status_nxt = STATUS_RESET;
    status_nxt[ST_PIN0_OSC] = amp_out_nxt;
    status_nxt[ST_PIN0_DIVIDED_CLOCK_OUTPUT] = div_run;
    status_nxt[ST_PIN1_OSC] = amp_in_nxt;
    status_nxt[ST_DIVIDED_CLOCK_OUTPUT_EN] = divided_clock_output_en_r;
    status_nxt[ST_RSVD_HI:ST_RSVD_LO] = RSVD_READ_VAL; // R9
    status_nxt[ST_FIXED_ZERO] = FIXED_ZERO_VAL; // R10
    status_nxt[ST_FIXED_ONE] = FIXED_ONE_VAL; // R11
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_c_bit0_out <= 1'b0;
      port_c_bit0_oe <= 1'b0; // R1
      port_c_bit0_pullup <= 1'b0; // R1
      port_c_bit1_out <= 1'b0;
      port_c_bit1_oe <= 1'b0; // R1
      port_c_bit1_pullup <= 1'b0; // R1
    end else begin
      {port_c_bit0_out, port_c_bit0_oe, port_c_bit0_pullup} <= pad0_nxt;
      {port_c_bit1_out, port_c_bit1_oe, port_c_bit1_pullup} <= pad1_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_amp_output <= 1'b0;
      osc_amp_input <= 1'b0;
      osc_input_level <= 1'b0;
      divided_clock_output <= 1'b0;
      pin_value <= 2'h0;
      mux_status <= STATUS_RESET;
    end else begin
      osc_amp_output <= amp_out_nxt;
      osc_amp_input <= amp_in_nxt;
      osc_input_level <= osc_lvl_nxt;
      divided_clock_output <= divout_nxt;
      pin_value <= pad_sync;
      mux_status <= status_nxt;
    end
  end

endmodule : port_c_clock_mux
`default_nettype wire

/* port_c_clock_mux_assertions.sv */
// Concurrent checks on the port C function multiplexer ports.
// Assumes static config held for a few mclk cycles between changes.
`timescale 1ns/1ps
`default_nettype none
module port_c_mux_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire port_c_mux_pkg::clk_src_t cpu_clk_src,
  input wire logic xtal_osc_sel,
  input wire logic timer_from_xtal,
  input wire logic clock_output_enable,
  input wire logic [1:0] pin1_mode,
  input wire logic pin1_data,
  input wire logic port_c_bit0_oe,
  input wire logic port_c_bit0_pullup,
  input wire logic port_c_bit1_out,
  input wire logic port_c_bit1_oe,
  input wire logic port_c_bit1_pullup,
  input wire logic osc_amp_output,
  input wire logic osc_amp_input,
  input wire logic divided_clock_output,
  input wire logic [7:0] mux_status
);
  import port_c_mux_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic cry;
  assign cry = xtal_osc_sel | timer_from_xtal | (cpu_clk_src == CLK_SRC_XTAL);
  fixed_bits_a: assert property (
    mux_status[7:6] == 2'h2) else $error("fixed status bits wrong");
  reserved_zero_a: assert property (
    mux_status[5:4] == 2'h0) else $error("reserved status bits set");
  reset_idle_a: assert property (disable iff (1'b0)
    !resetn |-> {port_c_bit0_oe, port_c_bit0_pullup, port_c_bit1_oe,
    port_c_bit1_pullup, divided_clock_output} == 5'h00)
    else $error("pads active in reset");
  clk_refused_a: assert property (
    cry [*4] |-> !mux_status[ST_PIN0_DIVIDED_CLOCK_OUTPUT] && !divided_clock_output)
    else $error("divided clock with crystal");
  clk_on_a: assert property (
    (clock_output_enable && !cry) [*4] |->
    mux_status[ST_PIN0_DIVIDED_CLOCK_OUTPUT] && port_c_bit0_oe)
    else $error("divided clock not driven");
  clk_toggle_a: assert property (
    mux_status[ST_PIN0_DIVIDED_CLOCK_OUTPUT] && $past(mux_status[ST_PIN0_DIVIDED_CLOCK_OUTPUT]) |->
    divided_clock_output != $past(divided_clock_output))
    else $error("divided clock not toggling");
  pin0_osc_a: assert property (
    xtal_osc_sel [*3] |-> osc_amp_output && !port_c_bit0_oe)
    else $error("pin 0 not oscillator output");
  pin1_osc_a: assert property (
    (cpu_clk_src inside {CLK_SRC_EXT, CLK_SRC_XTAL}) [*3] |->
    osc_amp_input && !port_c_bit1_oe && mux_status[ST_PIN1_OSC])
    else $error("pin 1 not oscillator input");
  pin1_gpio_a: assert property (
    (!cry && cpu_clk_src != CLK_SRC_EXT && pin1_mode == MODE_PUSH_PULL) [*3]
    |-> port_c_bit1_oe && port_c_bit1_out == $past(pin1_data))
    else $error("pin 1 push-pull wrong");
endmodule : port_c_mux_checker
bind port_c_clock_mux port_c_mux_checker u_chk (.mclk, .resetn,
  .cpu_clk_src, .xtal_osc_sel, .timer_from_xtal, .clock_output_enable,
  .pin1_mode, .pin1_data, .port_c_bit0_oe, .port_c_bit0_pullup,
  .port_c_bit1_out, .port_c_bit1_oe, .port_c_bit1_pullup, .osc_amp_output,
  .osc_amp_input, .divided_clock_output, .mux_status);
`default_nettype wire

/* port_c_clock_mux_bench.sv */
// Random static configs on port_c_clock_mux, checked against a model.
// Assumes pad_load on the pads and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module port_c_clock_mux_bench;
  import port_c_mux_pkg::*;
  logic mclk, resetn, xo, tx, en, d0, d1, o0, e0, p0, o1, e1, p1;
  logic oo, oi, il, dc;
  clk_src_t src;
  logic [1:0] m0, m1, pv, ext, pad;
  logic [7:0] st;
  logic [31:0] rs;
  int errors, samples_checked;
  port_c_clock_mux DUT (.mclk, .resetn, .cpu_clk_src(src), .xtal_osc_sel(xo),
    .timer_from_xtal(tx), .clock_output_enable(en), .pin0_mode(m0),
    .pin1_mode(m1), .pin0_data(d0), .pin1_data(d1),
    .port_c_bit0_in(pad[0]), .port_c_bit1_in(pad[1]), .port_c_bit0_out(o0),
    .port_c_bit0_oe(e0), .port_c_bit0_pullup(p0), .port_c_bit1_out(o1),
    .port_c_bit1_oe(e1), .port_c_bit1_pullup(p1), .osc_amp_output(oo),
    .osc_amp_input(oi), .osc_input_level(il), .divided_clock_output(dc),
    .pin_value(pv), .mux_status(st));
  pad_load board (.out({o1, o0}), .oe({e1, e0}), .pull_en({p1, p0}),
    .ext, .pad);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // {oe, out, pullup} of a general purpose pin
  function automatic logic [2:0] pexp(input logic [1:0] m, input logic d);
    case (m)
      MODE_QUASI: return {~d, 2'h1};
      MODE_PUSH_PULL: return {1'h1, d, 1'h0};
      MODE_OPEN_DRAIN: return {~d, 2'h0};
      default: return 3'h0;
    endcase
  endfunction : pexp
  task automatic chk_stat(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_stat
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk_stat({4'h0, got}, {4'h0, exp});
  endtask : chk_pin
  task automatic reset_check;
    @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    chk_stat({e0, p0, e1, p1, dc, oo, oi, il}, 8'h00);
    chk_stat(st, 8'h80);
    repeat (11) @(negedge mclk);
    resetn = 1'b1;
    $display("reset test done");
  endtask : reset_check
  task automatic trial(input int n);
    logic cry, f1, c0;
    logic [2:0] v, w;
    @(negedge mclk);
    rs = xs(rs);
    src = clk_src_t'(rs[1:0]);
    xo = &rs[3:2];
    tx = &rs[5:4];
    en = rs[6];
    {d1, d0, m1, m0, ext} = rs[14:7];
    repeat (7) @(negedge mclk);
    cry = xo | tx | (src == CLK_SRC_XTAL);
    f1 = cry | (src == CLK_SRC_EXT);
    c0 = en & ~cry;
    v = cry ? 3'h0 : c0 ? 3'h4 : pexp(m0, d0);
    w = f1 ? 3'h0 : pexp(m1, d1);
    chk_pin({e0, o0 & e0 & ~c0, p0 & ~v[2], oo},
      {v[2], v[1] & v[2], v[0] & ~v[2], cry});
    chk_pin({e1, o1 & e1, p1 & ~w[2], oi},
      {w[2], w[1] & w[2], w[0] & ~w[2], f1});
    chk_pin({c0 | pv[0], pv[1], il, dc & cry},
      {c0 | (v[2] ? v[1] : v[0] | ext[0]), w[2] ? w[1] : w[0] | ext[1],
      f1 & ext[1], 1'b0});
    chk_stat(st, {4'h8, en, f1, c0, cry});
    $display("trial %0d done", n);
  endtask : trial
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    resetn = 1'b0;
    src = CLK_SRC_RC;
    {xo, tx, en} = 3'h0;
    {d1, d0, m1, m0, ext} = 8'h00;
    rs = 32'h1E37;
    reset_check();
    for (int n = 0; n < 80; n++) begin
      if (n == 40)
        reset_check();
      trial(n);
    end
    results();
  end
  initial begin
    #20000;
    errors++;
    results();
  end
endmodule : port_c_clock_mux_bench
`default_nettype wire

/* port_c_mux_pkg.sv */
// Constants and types for the two-pin port C function multiplexer.
// Assumes one clock domain (mclk) and an active-low asynchronous reset.
// Function
// [R1] Under reset both port pins are input only with pull-ups off.
// [R2] Port is two bits; each pin follows its own output-type setting.
// [R3] With clock output enabled, pin 0 drives the CPU clock divided by two.
// [R4] Divided clock only for RC, watchdog or external clock, never crystal timer.
// [R5] Crystal option selected: pin 0 carries the oscillator amplifier output.
// [R6] External or crystal clock selected: pin 1 feeds the oscillator input.
// [R7] Pin 1 is general I/O only on RC or watchdog clock without crystal timer.
// [R8] Software touches only defined special registers, for their purpose.
// [R9] Reserved bits are written zero; reads of them return any value.
// [R10] Fixed-zero bits read as zero and are written zero.
// [R11] Fixed-one bits read as one and are written one.
// [R12] Clock output enable is cleared by reset.
package port_c_mux_pkg;

  localparam int PIN_COUNT = 2;
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int DIV_RATIO = 2;
  localparam int SYNC_STAGES = 2;

  // Per-pin output type
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_INPUT_ONLY = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_INPUT_ONLY;

  // CPU clock source
  typedef enum logic [1:0] {
    CLK_SRC_RC = 2'h0,
    CLK_SRC_WDT = 2'h1,
    CLK_SRC_EXT = 2'h2,
    CLK_SRC_XTAL = 2'h3
  } clk_src_t;

  // Pin function, one-hot
  typedef enum logic [2:0] {
    FN_GPIO = 3'h1,
    FN_DIVIDED_CLOCK_OUTPUT = 3'h2,
    FN_OSC = 3'h4
  } pin_fn_t;

  // Status image layout
  localparam int STATUS_WIDTH = 8;
  localparam int ST_PIN0_OSC = 0;
  localparam int ST_PIN0_DIVIDED_CLOCK_OUTPUT = 1;
  localparam int ST_PIN1_OSC = 2;
  localparam int ST_DIVIDED_CLOCK_OUTPUT_EN = 3;
  localparam int ST_RSVD_LO = 4;
  localparam int ST_RSVD_HI = 5;
  localparam int ST_FIXED_ZERO = 6;
  localparam int ST_FIXED_ONE = 7;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 8'h80;
  localparam logic FIXED_ZERO_VAL = 1'h0;
  localparam logic FIXED_ONE_VAL = 1'h1;
  localparam logic [1:0] RSVD_READ_VAL = 2'h0;

endpackage : port_c_mux_pkg
